// [logic/dprs_pkg.sv]
// Constants shared by the power-down and reset sequencer.
// Assumes a free-running system clock at the rate given below.
package dprs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS    = 100;
    localparam int unsigned RST_MIN_PERIODS  = 4;
    localparam int unsigned LOCK_WAIT_MS     = 100;
    localparam int unsigned LOCK_WAIT_CYCLES =
        (LOCK_WAIT_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned MUTE_SAMPLES     = 1000;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL_LEFT   = 12'h000;
    localparam logic [11:0] ADDR_CTRL_RIGHT  = 12'h004;
    localparam logic [11:0] ADDR_STATUS      = 12'h008;
    localparam logic [11:0] ADDR_PINS        = 12'h00C;
    localparam int unsigned ATTEN_W          = 6;
    localparam int unsigned MUTE_BIT         = 6;
    localparam logic [6:0]  CTRL_RESET       = 7'h00;
    localparam int unsigned ST_READY_BIT     = 0;
    localparam int unsigned ST_LOCKED_BIT    = 1;
    localparam int unsigned ST_CFG_CHG_BIT   = 2;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DPRS_POWERDOWN,
        DPRS_CLEAR,
        DPRS_WAIT_LOCK,
        DPRS_RUN
    } dprs_state_t;

endpackage : dprs_pkg

// [logic/dprs_rst_sync.sv]
// Reset synchroniser for the power-down/reset pin.
// Assertion is seen at once; release passes two flip-flops first.
`timescale 1ns/1ps
`default_nettype none
module dprs_rst_sync (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic powerdown_reset_n,
    output var  logic engine_rst_n
);
    logic meta_q;
    logic meta_d;
    logic hold_q;
    logic hold_d;

    always_comb begin
        meta_d = 1'b1;
        hold_d = meta_q;
    end

    // ------------------------------------------------------------
    // Asynchronous assert, synchronous release
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge powerdown_reset_n) begin
        if (!powerdown_reset_n) begin
            meta_q <= 1'b0;
            hold_q <= 1'b0;
        end else if (!rst_b) begin
            meta_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            meta_q <= meta_d; // see (R11)
            hold_q <= hold_d; // see (R11)
        end
    end

    assign engine_rst_n = hold_q;
endmodule : dprs_rst_sync
`default_nettype wire

// [logic/dprs_sync.sv]
// Two-stage synchroniser for a bus of asynchronous levels.
// Assumes the inputs come from pins outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module dprs_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : dprs_sync
`default_nettype wire

// [logic/dprs_top.sv]
// Power-down and reset sequencer of a stereo audio converter.
// Assumes clk_sys is the free-running master clock and that an APB
// master on the same clock reaches the two channel control registers.
//
// How it works
// (R1) Pin low means power-down; high means ready.
// (R2) Controller keeps master clock running through reset.
// (R3) Controller holds reset pin low four clocks.
// (R4) Reset zeroes engine and shorts the amplifiers.
// (R5) Reset loads both channel registers with defaults.
// (R6) Controller waits 100 ms before using ports; the bench waits LOCK + 4 clocks after ready.
// (R7) Config pins accepted any time, asynchronously.
// (R8) Controller settles config pins before next word.
// (R9) Default: unmuted, attenuation zero.
// (R10) Controller mutes about 1000 samples after power-up; the model and bench never do, and MUTE_SAMPLES is unused.
// (R11) Reset release passes a two-stage synchroniser.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dprs_top
    import dprs_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = LOCK_WAIT_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        powerdown_reset_n,
    input  wire logic        input_format_select_0,
    input  wire logic        input_format_select_1,
    input  wire logic        word_length_select,
    input  wire logic        deemphasis_select,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    output var  logic        powerdown,
    output var  logic        engine_clear,
    output var  logic        amp_short,
    output var  logic        ready,
    output var  logic        mute_left,
    output var  logic        mute_right,
    output var  logic [5:0]  atten_left,
    output var  logic [5:0]  atten_right,
    output var  logic [1:0]  format_sel,
    output var  logic        word_len_sel,
    output var  logic        deemph_sel
);

    // ------------------------------------------------------------
    // Reset pin and configuration pin synchronisers
    // ------------------------------------------------------------
    logic       engine_rst_n;
    logic [3:0] pins_sync;

    dprs_rst_sync u_rst_sync (
        .clk_sys           (clk_sys),
        .rst_b             (rst_b),
        .powerdown_reset_n (powerdown_reset_n),
        .engine_rst_n      (engine_rst_n)
    );

    // The pins may change at any moment; two stages keep metastable
    // values away from the mode logic.
    dprs_sync #(.WIDTH(4)) u_pin_sync (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .async_in ({deemphasis_select, word_length_select,
                    input_format_select_1, input_format_select_0}),
        .sync_out (pins_sync)
    ); // see (R7)

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    localparam int unsigned CW = $clog2(LOCK_CYCLES + 1);

    dprs_state_t   state_q;
    dprs_state_t   state_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          pd_q;
    logic          pd_d;
    logic          clr_q;
    logic          clr_d;
    logic          rdy_q;
    logic          rdy_d;
    logic          lock_q;
    logic          lock_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            DPRS_POWERDOWN: begin
                if (engine_rst_n) begin
                    state_d = DPRS_CLEAR;
                end
            end
            DPRS_CLEAR: begin
                state_d = DPRS_WAIT_LOCK;
                cnt_d   = '0;
            end
            DPRS_WAIT_LOCK: begin
                if (cnt_q == CW'(LOCK_CYCLES - 1)) begin
                    state_d = DPRS_RUN;
                end else begin
                    cnt_d = cnt_q + CW'(1);
                end
            end
            DPRS_RUN: begin
                state_d = DPRS_RUN;
            end
        endcase
        if (!engine_rst_n) begin
            state_d = DPRS_POWERDOWN; // see (R1)
            cnt_d   = '0;
        end
        pd_d   = (state_d == DPRS_POWERDOWN); // see (R1)
        clr_d  = (state_d == DPRS_POWERDOWN) ||
                 (state_d == DPRS_CLEAR); // see (R4)
        rdy_d  = (state_d != DPRS_POWERDOWN); // see (R1)
        lock_d = (state_d == DPRS_RUN);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_q <= DPRS_POWERDOWN;
            cnt_q   <= '0;
            pd_q    <= 1'b1;
            clr_q   <= 1'b1;
            rdy_q   <= 1'b0;
            lock_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            pd_q    <= pd_d;
            clr_q   <= clr_d;
            rdy_q   <= rdy_d;
            lock_q  <= lock_d;
        end
    end

    // ------------------------------------------------------------
    // Channel control registers and APB slave
    // ------------------------------------------------------------
    logic [6:0]  ctrl_l_q;
    logic [6:0]  ctrl_l_d;
    logic [6:0]  ctrl_r_q;
    logic [6:0]  ctrl_r_d;
    logic [3:0]  pins_q;
    logic [3:0]  pins_d;
    logic        chg_q;
    logic        chg_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        ready_q;
    logic        ready_d;
    logic        err_q;
    logic        err_d;
    logic        acc;
    logic        hit;

    always_comb begin
        acc      = psel && penable && !ready_q;
        hit      = (paddr == ADDR_CTRL_LEFT) ||
                   (paddr == ADDR_CTRL_RIGHT) ||
                   (paddr == ADDR_STATUS) || (paddr == ADDR_PINS);
        ctrl_l_d = ctrl_l_q;
        ctrl_r_d = ctrl_r_q;
        pins_d   = pins_sync;
        chg_d    = chg_q;
        rdata_d  = '0;
        ready_d  = acc;
        err_d    = acc && !hit;
        if (pins_sync != pins_q) begin
            chg_d = 1'b1;
        end
        if (acc && pwrite) begin
            if (paddr == ADDR_CTRL_LEFT) begin
                ctrl_l_d = pwdata[MUTE_BIT:0];
            end
            // Writing a one clears the flag; a pin change in the same
            // cycle keeps it set so the event is not lost.
            if (paddr == ADDR_STATUS && pwdata[ST_CFG_CHG_BIT] &&
                pins_sync == pins_q) begin
                chg_d = 1'b0;
            end
            if (paddr == ADDR_CTRL_RIGHT) begin
                ctrl_r_d = pwdata[MUTE_BIT:0];
            end
        end
        if (acc && !pwrite) begin
            unique case (paddr)
                ADDR_CTRL_LEFT:  rdata_d = {25'h0000000, ctrl_l_q};
                ADDR_CTRL_RIGHT: rdata_d = {25'h0000000, ctrl_r_q};
                ADDR_STATUS: begin
                    rdata_d[ST_READY_BIT]   = rdy_q;
                    rdata_d[ST_LOCKED_BIT]  = lock_q;
                    rdata_d[ST_CFG_CHG_BIT] = chg_q;
                end
                ADDR_PINS:       rdata_d = {28'h0000000, pins_q};
                default:         rdata_d = '0;
            endcase
        end
        // The control registers are held at defaults while the
        // device is in power-down or clearing.
        if (clr_q) begin
            ctrl_l_d = CTRL_RESET; // see (R5) (R9)
            ctrl_r_d = CTRL_RESET; // see (R5) (R9)
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl_l_q <= CTRL_RESET;
            ctrl_r_q <= CTRL_RESET;
            pins_q   <= '0;
            chg_q    <= 1'b0;
            rdata_q  <= '0;
            ready_q  <= 1'b0;
            err_q    <= 1'b0;
        end else begin
            ctrl_l_q <= ctrl_l_d;
            ctrl_r_q <= ctrl_r_d;
            pins_q   <= pins_d;
            chg_q    <= chg_d;
            rdata_q  <= rdata_d;
            ready_q  <= ready_d;
            err_q    <= err_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign prdata       = rdata_q;
    assign pready       = ready_q;
    assign pslverr      = err_q;
    assign powerdown    = pd_q;
    assign engine_clear = clr_q; // see (R4)
    assign amp_short    = clr_q; // see (R4)
    assign ready        = rdy_q;
    assign mute_left    = ctrl_l_q[MUTE_BIT];
    assign mute_right   = ctrl_r_q[MUTE_BIT];
    assign atten_left   = ctrl_l_q[ATTEN_W-1:0];
    assign atten_right  = ctrl_r_q[ATTEN_W-1:0];
    assign format_sel   = pins_q[1:0];
    assign word_len_sel = pins_q[2];
    assign deemph_sel   = pins_q[3];

endmodule : dprs_top
`default_nettype wire

// [tb/dprs_assertions.sv]
// Checker on the ports of the power-down and reset sequencer.
// Assumes it is bound to dprs_top and shares its clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module dprs_assertions (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       powerdown_reset_n,
    input wire logic       input_format_select_0,
    input wire logic       input_format_select_1,
    input wire logic       word_length_select,
    input wire logic       deemphasis_select,
    input wire logic       powerdown,
    input wire logic       engine_clear,
    input wire logic       amp_short,
    input wire logic       ready,
    input wire logic       mute_left,
    input wire logic       mute_right,
    input wire logic [5:0] atten_left,
    input wire logic [5:0] atten_right,
    input wire logic [1:0] format_sel,
    input wire logic       word_len_sel,
    input wire logic       deemph_sel
);
    logic [3:0] pins_w;
    assign pins_w = {deemphasis_select, word_length_select,
                     input_format_select_1, input_format_select_0};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence pin_up_s;
        $rose(powerdown_reset_n) ##1 powerdown_reset_n [*5];
    endsequence
    sequence clr_tail_s;
        engine_clear ##1 !engine_clear;
    endsequence
    pd_hold_a: assert property (
        (!powerdown_reset_n) [*3] |-> powerdown && !ready)
        else $error("no power-down with pin low");
    pd_engine_a: assert property (
        powerdown |-> engine_clear)
        else $error("engine runs in power-down");
    amp_pair_a: assert property (
        engine_clear == amp_short)
        else $error("amplifier short differs");
    rel_sync_a: assert property (
        $rose(powerdown_reset_n) |-> powerdown [*2])
        else $error("release not synchronised");
    pd_exit_a: assert property (
        pin_up_s |-> !powerdown)
        else $error("power-down not left");
    clr_tail_a: assert property (
        $fell(powerdown) |-> clr_tail_s)
        else $error("engine clear tail wrong");
    ctrl_dflt_a: assert property (
        engine_clear && $past(engine_clear) |-> !mute_left &&
        !mute_right && atten_left == 6'h00 && atten_right == 6'h00)
        else $error("controls not default");
    cfg_follow_a: assert property (
        $stable(pins_w) [*4] |->
        {deemph_sel, word_len_sel, format_sel} == pins_w)
        else $error("config pins not followed");
endmodule : dprs_assertions
bind dprs_top dprs_assertions dprs_assertions_i (.clk_sys, .rst_b,
    .powerdown_reset_n, .input_format_select_0, .input_format_select_1,
    .word_length_select, .deemphasis_select, .powerdown, .engine_clear,
    .amp_short, .ready, .mute_left, .mute_right, .atten_left,
    .atten_right, .format_sel, .word_len_sel, .deemph_sel);
`default_nettype wire

// [tb/dprs_ctrl_model.sv]
// Model of the system controller driving reset and config pins.
// Assumes clk_sys is the free-running master clock.
`timescale 1ns/1ps
`default_nettype none
module dprs_ctrl_model
    import dprs_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       pd_req,
    input  wire logic [3:0] cfg_req,
    output var  logic       powerdown_reset_n,
    output var  logic [3:0] cfg_pins
);
    // One process drives every output; the pins read unknown only until
    // the first edge, while the system reset still holds the block.
    int unsigned low_q = 0;
    // Pins move on a clock edge, long before any audio word starts.
    always @(posedge clk_sys) begin
        cfg_pins <= cfg_req;
        if (!pd_req) begin
            low_q             <= 0;
            powerdown_reset_n <= 1'b0;
        end else if (low_q < RST_MIN_PERIODS) begin
            low_q <= low_q + 1;
        end else begin
            powerdown_reset_n <= 1'b1;
        end
    end
endmodule : dprs_ctrl_model
`default_nettype wire

// [tb/dprs_top_tb.sv]
// Self-checking bench for the power-down and reset sequencer.
// Assumes the controller model and bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dprs_top_tb
    import dprs_pkg::*;
;
    localparam int unsigned LOCK = 16;
    logic        clk_sys = 1'b0;
    logic        rst_b, pd_req, psel, penable, pwrite, pready, pslverr;
    logic        powerdown, engine_clear, amp_short, ready, err;
    logic        mute_left, mute_right, word_len_sel, deemph_sel;
    logic        powerdown_reset_n;
    logic [3:0]  cfg_req, cfg_pins;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  atten_left, atten_right;
    logic [1:0]  format_sel;
    int          mismatches = 0;
    int          checks_done = 0;
    dprs_top #(.LOCK_CYCLES(LOCK)) dprs_top_i (
        .clk_sys, .rst_b, .powerdown_reset_n,
        .input_format_select_0(cfg_pins[0]),
        .input_format_select_1(cfg_pins[1]),
        .word_length_select(cfg_pins[2]),
        .deemphasis_select(cfg_pins[3]),
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .powerdown, .engine_clear, .amp_short, .ready,
        .mute_left, .mute_right, .atten_left, .atten_right,
        .format_sel, .word_len_sel, .deemph_sel);
    dprs_ctrl_model dprs_ctrl_model_i (.clk_sys, .pd_req, .cfg_req,
        .powerdown_reset_n, .cfg_pins);
    always #50 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // The master never counts wait states; only the watchdog ends a hang.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] d,
                       output logic e);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic wake;
        pd_req <= 1'b1;
        while (ready !== 1'b1) @(posedge clk_sys);
        chk("powerdown", 32'h0, {31'h0, powerdown});
        repeat (LOCK + 4) @(posedge clk_sys);
    endtask : wake
    task automatic print_verdict;
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        $display("Error watchdog expected end seen hang");
        print_verdict();
    end
    initial begin
        rst_b = 1'b0;
        pd_req = 1'b0;
        cfg_req = 4'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("powerdown", 32'h1, {31'h0, powerdown});
        chk("amp_short", 32'h1, {31'h0, amp_short});
        wake();
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk("status", 32'h3, rd & 32'h3);
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, i ? ADDR_CTRL_RIGHT : ADDR_CTRL_LEFT, 32'h0, rd, err);
            chk("ctrl", 32'h0, rd);
        end
        apb(1'b1, ADDR_CTRL_LEFT, 32'h45, rd, err);
        apb(1'b1, ADDR_CTRL_RIGHT, 32'h3F, rd, err);
        chk("left", 32'h45, {25'h0, mute_left, atten_left});
        chk("right", 32'h3F, {25'h0, mute_right, atten_right});
        pd_req <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk("left", 32'h0, {25'h0, mute_left, atten_left});
        chk("clear", 32'h1, {31'h0, engine_clear});
        wake();
        apb(1'b0, ADDR_CTRL_RIGHT, 32'h0, rd, err);
        chk("right", 32'h0, rd);
        for (int i = 0; i < 16; i++) begin
            cfg_req <= 4'(i);
            repeat (6) @(posedge clk_sys);
            chk("cfg", 32'(i), {28'h0, deemph_sel, word_len_sel,
                format_sel});
            apb(1'b0, ADDR_PINS, 32'h0, rd, err);
            chk("pins", 32'(i), rd & 32'hF);
        end
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk("cfg_chg", 32'h4, rd & 32'h4);
        apb(1'b1, ADDR_STATUS, 32'h4, rd, err);
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk("cfg_chg", 32'h0, rd & 32'h4);
        apb(1'b0, 12'h010, 32'h0, rd, err);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("prdata", 32'h0, rd);
        print_verdict();
    end
endmodule : dprs_top_tb
`default_nettype wire
